// >>> verilog/sacs_pkg.sv
// Shared constants and types of the conversion sequencer
package sacs_pkg;
    // ------------------------------------------------------------
    // Bus address and result
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_UPPER = 3'h3;
    localparam int RESULT_BITS = 16;
    localparam int BYTE_BITS = 8;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MCLK_HZ = 200000000;
    localparam int CONV_CLK_HZ = 4000000;
    // Cycles of mclk per conversion-clock step (round down: step at least as fast)
    localparam int CONV_STEP_CYCLES = MCLK_HZ / CONV_CLK_HZ;
    localparam int ACQ_SCL_CYCLES = 2;
    localparam int MAX_BIT_RATE_HZ = 1700000;
    // ------------------------------------------------------------
    // Reset values and FIFO depth
    // ------------------------------------------------------------
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam int FIFO_DEPTH = 8;
    // ------------------------------------------------------------
    // Link-side states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        LK_IDLE = 7'h01,
        LK_ADDR = 7'h02,
        LK_AACK = 7'h04,
        LK_ACQ = 7'h08,
        LK_CONV = 7'h10,
        LK_SEND = 7'h20,
        LK_MACK = 7'h40
    } sacs_link_t;
    // Conversion-side states
    typedef enum logic [2:0] {
        CV_OFF = 3'h1,
        CV_RUN = 3'h2,
        CV_DONE = 3'h4
    } sacs_conv_t;
endpackage : sacs_pkg

// >>> verilog/sacs_fifo.sv
// Small FIFO that carries result bytes from the converter to the last_result status output
module sacs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and control
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Write side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Read side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic [WIDTH-1:0] dout;
        logic dval;
    } sacs_fifo_st_t;
    logic [WIDTH-1:0] mem [DEPTH];
    sacs_fifo_st_t st_ff, nxt_st;
    logic full, empty, wr, rd;

    // ------------------------------------------------------------
    // Flags: full when pointers differ only in wrap bit
    // ------------------------------------------------------------
    assign full = (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]) && (st_ff.wp[AW] != st_ff.rp[AW]);
    assign empty = (st_ff.wp == st_ff.rp);
    assign in_ready = !full;
    assign wr = in_valid && !full && ce;
    // Output register refills when empty or being taken
    assign rd = !empty && (!st_ff.dval || out_ready) && ce;
    assign out_valid = st_ff.dval;
    assign out_data = st_ff.dout;

    // Next state
    always_comb begin
        nxt_st = st_ff;
        if (wr) begin
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (out_ready && st_ff.dval) begin
            nxt_st.dval = 1'b0;
        end
        if (rd) begin
            nxt_st.rp = st_ff.rp + 1'b1;
            nxt_st.dout = mem[st_ff.rp[AW-1:0]];
            nxt_st.dval = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge mclk) begin
        if (wr) begin
            mem[st_ff.wp[AW-1:0]] <= in_data;
        end
    end
endmodule : sacs_fifo

// >>> verilog/sacs_sequencer.sv
// Conversion sequencer: serial slave at the link, SAR engine on mclk
// Notes on behaviour
// - Track exactly two serial clocks before conversion
// - Hold otherwise; hold before conversion starts
// - Stretch serial clock low while converting
// - Unipolar SAR stepped by 4MHz clock
// - Result is 16-bit unsigned, sent serially
// - Power-up lands in shutdown
// - Reference-adjust strapped high selects external reference
// - Link bit rate at most 1.7MHz
// - Address is 011 plus four strap bits
// - Acknowledge address, then acquire and convert
// - Send upper byte first, then lower
// - Power up when conversion starts, after the track clocks; shut down after
module sacs_sequencer #(
    parameter int RES_BITS = sacs_pkg::RESULT_BITS
) (
    // System clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Link clock (serial clock from the master) and data pin
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Clock stretch: pulls the serial clock low when oe_n is low
    output logic scl_out,
    output logic scl_oe_n,
    // Straps, synchronised inside
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic addr_strap_bit3,
    input wire logic reference_adjust_pin,
    // Analog front end control
    output logic track_en,
    output logic conv_powered,
    output logic ext_ref_mode,
    output logic [15:0] dac_code,
    input wire logic comp_in,
    // Status
    output logic conv_busy,
    output logic [15:0] last_result
);
    // ------------------------------------------------------------
    // Synchronisers (mclk domain)
    // ------------------------------------------------------------
    logic [4:0] strap_s1_ff, strap_s2_ff;
    logic comp_s1_ff, comp_s2_ff;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strap_s1_ff <= 5'h00;
            strap_s2_ff <= 5'h00;
            comp_s1_ff <= 1'b0;
            comp_s2_ff <= 1'b0;
        end else if (ce) begin
            strap_s1_ff <= {reference_adjust_pin, addr_strap_bit3, addr_strap_bit2,
                addr_strap_bit1, addr_strap_bit0};
            strap_s2_ff <= strap_s1_ff;
            comp_s1_ff <= comp_in;
            comp_s2_ff <= comp_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // Link domain (serial clock); sda sampled on rising edge
    // ------------------------------------------------------------
    typedef struct packed {
        sacs_pkg::sacs_link_t st;
        logic [3:0] bitc;
        logic [7:0] shf;
        logic [1:0] acqc;
        logic track;
        logic start_tgl;
        logic byte_hi;
        logic sda_low;
        logic [6:0] my_addr;
    } sacs_lk_st_t;
    sacs_lk_st_t lk_ff, nxt_lk;
    // Address straps crossing into the link domain
    logic [3:0] lstrap_s1_ff, lstrap_s2_ff;
    logic start_seen_ff;

    // Two-flop strap crossing on the serial clock
    always_ff @(posedge scl_clk) begin
        lstrap_s1_ff <= {addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
        lstrap_s2_ff <= lstrap_s1_ff;
    end

    // Result word read across from mclk: loaded one mclk before the stretch ends and
    // steady until the next conversion. The held-low clock is the handshake, so a
    // master must leave the stretch time to engage before its next rising edge
    logic [15:0] held_result;

    // Link state machine; a frame starts on the first serial clock after idle
    always_comb begin
        nxt_lk = lk_ff;
        nxt_lk.my_addr = {sacs_pkg::ADDR_UPPER, lstrap_s2_ff[3:0]};
        unique case (lk_ff.st)
            sacs_pkg::LK_IDLE: begin
                nxt_lk.shf = {7'h00, sda_in};
                nxt_lk.bitc = 4'h1;
                nxt_lk.sda_low = 1'b0;
                nxt_lk.st = sacs_pkg::LK_ADDR;
            end
            sacs_pkg::LK_ADDR: begin
                nxt_lk.shf = {lk_ff.shf[6:0], sda_in};
                nxt_lk.bitc = lk_ff.bitc + 4'h1;
                if (lk_ff.bitc == 4'h8) begin
                    // Ninth clock of a frame for another device passes unanswered
                    nxt_lk.st = sacs_pkg::LK_IDLE;
                end else if (lk_ff.bitc == 4'h7 && lk_ff.shf[6:0] == lk_ff.my_addr) begin
                    // Match on the seven address bits; R/W is ignored here
                    nxt_lk.sda_low = 1'b1;
                    nxt_lk.st = sacs_pkg::LK_AACK;
                end
            end
            sacs_pkg::LK_AACK: begin
                nxt_lk.sda_low = 1'b0;
                nxt_lk.track = 1'b1;
                nxt_lk.acqc = 2'h1;
                nxt_lk.st = sacs_pkg::LK_ACQ;
            end
            sacs_pkg::LK_ACQ: begin
                if (lk_ff.acqc == 2'(sacs_pkg::ACQ_SCL_CYCLES)) begin
                    nxt_lk.track = 1'b0;
                    nxt_lk.start_tgl = !lk_ff.start_tgl;
                    nxt_lk.st = sacs_pkg::LK_CONV;
                end else begin
                    nxt_lk.acqc = lk_ff.acqc + 2'h1;
                end
            end
            sacs_pkg::LK_CONV: begin
                // Clock is held low, so the next edge means the result is stored
                nxt_lk.shf = held_result[15:8];
                nxt_lk.byte_hi = 1'b1;
                nxt_lk.bitc = 4'h0;
                nxt_lk.sda_low = !held_result[15];
                nxt_lk.st = sacs_pkg::LK_SEND;
            end
            sacs_pkg::LK_SEND: begin
                nxt_lk.bitc = lk_ff.bitc + 4'h1;
                nxt_lk.shf = {lk_ff.shf[6:0], 1'b0};
                nxt_lk.sda_low = !lk_ff.shf[6];
                if (lk_ff.bitc == 4'h7) begin
                    nxt_lk.sda_low = 1'b0;
                    nxt_lk.st = sacs_pkg::LK_MACK;
                end
            end
            sacs_pkg::LK_MACK: begin
                if (sda_in) begin
                    nxt_lk.st = sacs_pkg::LK_IDLE;
                end else if (lk_ff.byte_hi) begin
                    nxt_lk.shf = held_result[7:0];
                    nxt_lk.byte_hi = 1'b0;
                    nxt_lk.bitc = 4'h0;
                    nxt_lk.sda_low = !held_result[7];
                    nxt_lk.st = sacs_pkg::LK_SEND;
                end else begin
                    // Acknowledged low byte: convert again
                    nxt_lk.track = 1'b1;
                    nxt_lk.acqc = 2'h1;
                    nxt_lk.st = sacs_pkg::LK_ACQ;
                end
            end
        endcase
    end

    // Link registers; reset is the power-on one, ce also gates here
    always_ff @(posedge scl_clk) begin
        if (!rst_n) begin
            lk_ff <= '{st: sacs_pkg::LK_IDLE, default: '0};
        end else if (ce) begin
            lk_ff <= nxt_lk;
        end
    end

    // ------------------------------------------------------------
    // Conversion domain (mclk)
    // ------------------------------------------------------------
    typedef struct packed {
        sacs_pkg::sacs_conv_t st;
        logic [7:0] div;
        logic [4:0] bitn;
        logic [15:0] trial;
        logic [15:0] acc;
        logic stretch;
        logic pwr;
        logic ext_ref;
        logic track;
        logic [15:0] result;
    } sacs_cv_st_t;
    sacs_cv_st_t cv_ff, nxt_cv;
    logic st_s1_ff, st_s2_ff, st_s3_ff, tr_s1_ff, tr_s2_ff;
    logic start_pulse;
    localparam logic [7:0] STEP_LAST = 8'(sacs_pkg::CONV_STEP_CYCLES - 1);

    // Crossing of start toggle and track level into mclk
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_s1_ff <= 1'b0;
            st_s2_ff <= 1'b0;
            st_s3_ff <= 1'b0;
            tr_s1_ff <= 1'b0;
            tr_s2_ff <= 1'b0;
        end else if (ce) begin
            st_s1_ff <= lk_ff.start_tgl;
            st_s2_ff <= st_s1_ff;
            st_s3_ff <= st_s2_ff;
            tr_s1_ff <= lk_ff.track;
            tr_s2_ff <= tr_s1_ff;
        end
    end
    assign start_pulse = st_s2_ff ^ st_s3_ff;

    // SAR engine: one bit decision per 4MHz step
    always_comb begin
        nxt_cv = cv_ff;
        nxt_cv.ext_ref = strap_s2_ff[4];
        nxt_cv.track = tr_s2_ff;
        unique case (cv_ff.st)
            sacs_pkg::CV_OFF: begin
                nxt_cv.pwr = 1'b0;
                if (start_pulse) begin
                    nxt_cv.pwr = 1'b1;
                    nxt_cv.stretch = 1'b1;
                    nxt_cv.acc = 16'h0000;
                    nxt_cv.trial = 16'h8000;
                    nxt_cv.bitn = 5'h00;
                    nxt_cv.div = 8'h00;
                    nxt_cv.st = sacs_pkg::CV_RUN;
                end
            end
            sacs_pkg::CV_RUN: begin
                if (cv_ff.div == STEP_LAST) begin
                    nxt_cv.div = 8'h00;
                    // Unipolar: keep trial bit when input is at or above the DAC
                    if (comp_s2_ff) begin
                        nxt_cv.acc = cv_ff.acc | cv_ff.trial;
                    end
                    nxt_cv.trial = cv_ff.trial >> 1;
                    nxt_cv.bitn = cv_ff.bitn + 5'h01;
                    if (cv_ff.bitn == 5'(RES_BITS - 1)) begin
                        nxt_cv.st = sacs_pkg::CV_DONE;
                    end
                end else begin
                    nxt_cv.div = cv_ff.div + 8'h01;
                end
            end
            sacs_pkg::CV_DONE: begin
                nxt_cv.result = cv_ff.acc;
                nxt_cv.stretch = 1'b0;
                nxt_cv.pwr = 1'b0;
                nxt_cv.st = sacs_pkg::CV_OFF;
            end
            default: begin
                nxt_cv.st = sacs_pkg::CV_OFF;
            end
        endcase
    end

    // Conversion registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cv_ff <= '{st: sacs_pkg::CV_OFF, default: '0};
        end else if (ce) begin
            cv_ff <= nxt_cv;
        end
    end

    // Stored result as the link side reads it
    assign held_result = cv_ff.result;

    // Pulse on the same mclk edge that loads the result, to log it in the FIFO
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            start_seen_ff <= 1'b0;
        end else if (ce) begin
            start_seen_ff <= (cv_ff.st == sacs_pkg::CV_DONE);
        end
    end

    // ------------------------------------------------------------
    // Result byte FIFO (status history of sent results)
    // ------------------------------------------------------------
    logic fifo_ready, fifo_valid;
    logic [7:0] fifo_data;
    sacs_fifo #(.WIDTH(sacs_pkg::BYTE_BITS), .DEPTH(sacs_pkg::FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(start_seen_ff),
        .in_ready(fifo_ready),
        .in_data(cv_ff.result[15:8]),
        .out_valid(fifo_valid),
        .out_ready(1'b1),
        .out_data(fifo_data)
    );

    // ------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            track_en <= 1'b0;
            conv_powered <= 1'b0;
            ext_ref_mode <= 1'b0;
            dac_code <= 16'h0000;
            conv_busy <= 1'b0;
            last_result <= sacs_pkg::RESULT_RST;
            scl_out <= 1'b0;
            scl_oe_n <= 1'b1;
        end else if (ce) begin
            track_en <= cv_ff.track && !cv_ff.stretch;
            conv_powered <= cv_ff.pwr;
            ext_ref_mode <= cv_ff.ext_ref;
            dac_code <= cv_ff.acc | cv_ff.trial;
            conv_busy <= cv_ff.stretch || !fifo_ready;
            if (fifo_valid) begin
                last_result <= {fifo_data, cv_ff.result[7:0]};
            end
            scl_out <= 1'b0;
            scl_oe_n <= !cv_ff.stretch;
        end
    end

    // Data pin driven from the link register on the falling serial edge
    always_ff @(negedge scl_clk) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            sda_out <= 1'b0;
            sda_oe_n <= !lk_ff.sda_low;
        end
    end
endmodule : sacs_sequencer

// >>> test/sacs_sequencer_properties.sv
// Concurrent checks on the conversion sequencer ports
module sacs_sequencer_properties #(
    parameter int RES_BITS = sacs_pkg::RESULT_BITS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pins
    input wire logic reference_adjust_pin,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // Converter status
    input wire logic track_en,
    input wire logic conv_powered,
    input wire logic ext_ref_mode,
    input wire logic conv_busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Some slack for sync stages around the nominal step count
    localparam int CONV_MIN = (RES_BITS - 1) * sacs_pkg::CONV_STEP_CYCLES;
    localparam int CONV_MAX = (RES_BITS + 2) * sacs_pkg::CONV_STEP_CYCLES;
    logic [15:0] busy_cnt_ff;
    // Length of the running conversion in mclk cycles
    always_ff @(posedge mclk) begin
        if (!rst_n || !conv_busy) begin
            busy_cnt_ff <= 16'h0000;
        end else begin
            busy_cnt_ff <= busy_cnt_ff + 16'h0001;
        end
    end
    // --------------------------------------------------------
    // Assertions
    // --------------------------------------------------------
    a_hold_in_conv: assert property (conv_busy |-> !track_en)
        else $error("switch tracks during conversion");
    a_stretch_start: assert property ($rose(conv_busy) |-> ##[0:20] !scl_oe_n)
        else $error("clock not stretched after conversion start");
    a_release_late: assert property ($rose(scl_oe_n) |-> !conv_busy)
        else $error("clock released while converting");
    a_conv_length: assert property ($fell(conv_busy) |->
        busy_cnt_ff >= CONV_MIN && busy_cnt_ff <= CONV_MAX)
        else $error("conversion length off the step clock");
    a_busy_powered: assert property (conv_busy |-> conv_powered)
        else $error("converting while powered down");
    a_auto_off: assert property ($fell(conv_busy) |-> ##[0:8] !conv_powered)
        else $error("no shutdown after conversion");
    a_reset_off: assert property (disable iff (1'b0)
        !rst_n [*3] |=> !conv_powered && !conv_busy && scl_oe_n)
        else $error("not in shutdown after reset");
    a_ext_ref: assert property ($stable(reference_adjust_pin) [*5] |->
        ext_ref_mode == reference_adjust_pin)
        else $error("reference mode does not follow strap");
    a_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("pin driven high");
    // Main scenarios reached
    c_conv: cover property ($rose(conv_busy));
    c_ack: cover property ($fell(sda_oe_n));
    c_track: cover property ($rose(track_en));
    c_ext: cover property ($rose(ext_ref_mode));
endmodule : sacs_sequencer_properties

bind sacs_sequencer sacs_sequencer_properties #(.RES_BITS(RES_BITS)) i_sacs_sequencer_properties (
    .mclk(mclk), .rst_n(rst_n), .reference_adjust_pin(reference_adjust_pin),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .track_en(track_en), .conv_powered(conv_powered), .ext_ref_mode(ext_ref_mode),
    .conv_busy(conv_busy)
);

// >>> test/sacs_master_model.sv
// Serial bus master model: clocks frames, honours stretch, reads bytes
module sacs_master_model (
    // Device side of the two wires
    input wire logic scl_oe_n,
    input wire logic scl_out,
    input wire logic sda_oe_n,
    input wire logic sda_out,
    input wire logic track_en,
    // Wire levels
    output logic scl_clk,
    output logic sda_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic m_scl = 1'b1;
    logic m_sda = 1'b1;
    realtime trk_t0 = 0.0;
    int trk_ns = 0;
    // Pull-ups: a line nobody pulls low reads high
    assign scl_clk = m_scl & (scl_oe_n | scl_out);
    assign sda_in = m_sda & (sda_oe_n | sda_out);
    // Length of the track phase as the pin shows it, in ns
    always @(posedge track_en) begin
        trk_t0 = $realtime;
    end
    always @(negedge track_en) begin
        trk_ns = int'($realtime - trk_t0);
    end
    // Clock edges that let the link side leave reset
    task automatic pulses;
        repeat (2) begin
            #3 m_scl = 1'b0;
            #3 m_scl = 1'b1;
        end
    endtask : pulses
    // One clock: data after the fall, rise only once the line is free
    task automatic bit_clk(input logic d, output logic q);
        int n;
        n = 0;
        m_scl = 1'b0;
        #1 m_sda = d;
        #2 m_scl = 1'b1;
        while (scl_clk !== 1'b1 && n < 20000) begin
            #1 n++;
        end
        q = sda_in;
        #3;
    endtask : bit_clk
    // Address, ack, two track clocks, stretched clock, two bytes
    task automatic frame(input logic [6:0] addr, output logic ack,
                         output logic [15:0] data, output int trk);
        logic q;
        logic [7:0] ab;
        ab = {addr, 1'b1};
        trk_ns = 0;
        data = 16'h0000;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(ab[i], q);
        end
        bit_clk(1'b1, q);
        ack = ~q;
        if (ack) begin
            bit_clk(1'b1, q);
            bit_clk(1'b1, q);
            // Long low phase so a slow stretch is caught before the rise
            m_scl = 1'b0;
            #100;
            bit_clk(1'b1, q);
            for (int i = 15; i >= 0; i--) begin
                bit_clk(1'b1, q);
                data[i] = q;
                if (i == 8) begin
                    bit_clk(1'b0, q);
                end
            end
            bit_clk(1'b1, q);
        end
        trk = trk_ns;
        #20;
    endtask : frame
endmodule : sacs_master_model

// >>> test/sacs_sequencer_test.sv
// Self-checking bench for the conversion sequencer
module sacs_sequencer_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [3:0] st = 4'ha;
    logic ref_adj = 1'b0;
    logic comp_in = 1'b0;
    logic [15:0] analog_input_pin = 16'h0000;
    logic scl_clk, sda_in, sda_out, sda_oe_n, scl_out, scl_oe_n;
    logic track_en, conv_powered, ext_ref_mode, conv_busy;
    logic [15:0] dac_code, last_result;
    int failures = 0;
    int tests_run = 0;
    // --------------------------------------------------------
    // Clock, comparator, instances
    // --------------------------------------------------------
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    // Comparator: high while the input is at or above the trial code
    always @(posedge mclk) begin
        comp_in <= (analog_input_pin >= dac_code);
    end
    sacs_sequencer i_sacs_sequencer (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .scl_clk(scl_clk), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .addr_strap_bit0(st[0]), .addr_strap_bit1(st[1]), .addr_strap_bit2(st[2]),
        .addr_strap_bit3(st[3]), .reference_adjust_pin(ref_adj), .track_en(track_en),
        .conv_powered(conv_powered), .ext_ref_mode(ext_ref_mode), .dac_code(dac_code),
        .comp_in(comp_in), .conv_busy(conv_busy), .last_result(last_result)
    );
    sacs_master_model i_sacs_master_model (
        .scl_oe_n(scl_oe_n), .scl_out(scl_out), .sda_oe_n(sda_oe_n), .sda_out(sda_out),
        .track_en(track_en), .scl_clk(scl_clk), .sda_in(sda_in)
    );
    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task automatic t_reset;
        check("powered", conv_powered, 16'h0000);
        check("busy", conv_busy, 16'h0000);
        check("track", track_en, 16'h0000);
        check("stretch", scl_oe_n, 16'h0001);
    endtask : t_reset
    // Full-scale ends and asymmetric bytes expose order and width faults
    task automatic t_convert;
        logic [15:0] vals [4] = '{16'h0000, 16'hffff, 16'h12ab, 16'h8001};
        logic ack;
        logic [15:0] d;
        int trk;
        foreach (vals[i]) begin
            analog_input_pin <= vals[i];
            @(posedge mclk);
            fork
                i_sacs_master_model.frame({3'h3, st}, ack, d, trk);
                begin
                    repeat (400) @(posedge mclk);
                    check("scl held", scl_clk, 16'h0000);
                    check("hold mid", track_en, 16'h0000);
                    check("powered mid", conv_powered, 16'h0001);
                end
            join
            check("ack", ack, 16'h0001);
            // Two 6 ns serial clocks of track, seen through one mclk of sync jitter
            check("track window", 16'(trk >= 10 && trk <= 15), 16'h0001);
            check("data", d, vals[i]);
            check("dac settled", dac_code, vals[i]);
            check("result", last_result, vals[i]);
            repeat (8) @(posedge mclk);
            check("powered after", conv_powered, 16'h0000);
        end
    endtask : t_convert
    // Each strap alone, with a wrong strap field and a wrong fixed part
    task automatic t_addr;
        logic ack;
        logic [15:0] d;
        int trk;
        for (int k = 0; k < 4; k++) begin
            st <= 4'h1 << k;
            repeat (8) @(posedge mclk);
            i_sacs_master_model.frame({3'h3, st ^ 4'hf}, ack, d, trk);
            check("bad strap ack", ack, 16'h0000);
            i_sacs_master_model.frame({3'h7, st}, ack, d, trk);
            check("bad upper ack", ack, 16'h0000);
            check("idle powered", conv_powered, 16'h0000);
            i_sacs_master_model.frame({3'h3, st}, ack, d, trk);
            check("good ack", ack, 16'h0001);
            check("good data", d, analog_input_pin);
        end
    endtask : t_addr
    task automatic t_ref;
        ref_adj <= 1'b1;
        repeat (10) @(posedge mclk);
        check("ext ref", ext_ref_mode, 16'h0001);
        ref_adj <= 1'b0;
        repeat (10) @(posedge mclk);
        check("int ref", ext_ref_mode, 16'h0000);
    endtask : t_ref
    // Main sequence; the link side needs clock edges inside reset
    initial begin
        i_sacs_master_model.pulses();
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_convert();
        t_addr();
        t_ref();
        wrap_up();
    end
    // Eight conversions take a little over 32 us; far beyond that means a hang
    initial begin
        #200us;
        failures++;
        wrap_up();
    end
endmodule : sacs_sequencer_test
